// >>> bte_pkg.sv
package bte_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;

   // ctrl fields
   localparam int CTRL_EE = 0;
   localparam int CTRL_ME = 1;
   localparam int CTRL_EMC = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;

   // status fields
   localparam int ST_RETRY_OFF = 0;
   localparam int ST_CHECKSTOP = 1;
   localparam int ST_EXT_TAKEN = 2;
   localparam int ST_SMI_TAKEN = 3;
   localparam int ST_MCHK_TAKEN = 4;
   localparam int ST_BUS_ERR = 5;
   localparam int ST_BUSY = 6;
   localparam logic [3:0] STICKY_RESET = 4'h0;

   // ----------------------------------------
   // transfer shape and synchronizer depth
   // ----------------------------------------
   localparam int BURST_BEATS = 4;
   localparam int SYNC_STAGES = 2;

   // ----------------------------------------
   // data tenure states
   // ----------------------------------------
   typedef enum logic [2:0] {
      BTE_IDLE = 3'b001,
      BTE_BEAT = 3'b010,
      BTE_HALT = 3'b100
   } bte_state_e;

endpackage

// >>> bte_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// multi-flop level synchronizer
// ----------------------------------------
module bte_sync #(
   parameter int WIDTH = 1,
   parameter int STAGES = 2
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_r [STAGES];
   logic [WIDTH-1:0] stage_nxt [STAGES];

   initial begin
      if (STAGES < 2) begin
         $error("bte_sync needs at least two stages");
      end
   end

   // shift chain; first stage feeds only the second
   always_comb begin
      stage_nxt[0] = async_in;
      for (int i = 1; i < STAGES; i++) begin
         stage_nxt[i] = stage_r[i-1];
      end
   end

   always_ff @(posedge core_clk) begin
      for (int i = 0; i < STAGES; i++) begin
         if (rst) begin
            stage_r[i] <= '0;
         end else begin
            stage_r[i] <= stage_nxt[i];
         end
      end
   end

   assign sync_out = stage_r[STAGES-1];

endmodule
`default_nettype wire

// >>> bte_strap.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// level capture at reset release
// ----------------------------------------
module bte_strap (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic strap_in,
   output logic strap_r
);

   logic in_reset_r;
   logic in_reset_nxt;
   logic strap_nxt;

   // capture on the first edge after release; reset takes constants only
   always_comb begin
      in_reset_nxt = 1'b0;
      strap_nxt = strap_r;
      if (in_reset_r) begin
         strap_nxt = strap_in;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         in_reset_r <= 1'b1;
         strap_r <= 1'b0;
      end else begin
         in_reset_r <= in_reset_nxt;
         strap_r <= strap_nxt;
      end
   end

endmodule
`default_nettype wire

// >>> bte_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bus termination and exception inputs
// ----------------------------------------
module bte_top #(
   parameter int MAX_BEATS = bte_pkg::BURST_BEATS,
   parameter int SYNC_STAGES = bte_pkg::SYNC_STAGES
) (
   input wire logic core_clk,
   input wire logic rst,
   // register port
   input wire logic [bte_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [bte_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [bte_pkg::DATA_W-1:0] reg_rdata,
   // core transfer request
   input wire logic xfer_start,
   input wire logic xfer_read,
   input wire logic xfer_burst,
   // bus termination inputs, bus clock domain
   input wire logic transfer_ack,
   input wire logic beat_retry,
   input wire logic bus_error_ack,
   // asynchronous exception inputs
   input wire logic ext_irq,
   input wire logic sysmgmt_irq,
   input wire logic machine_check_in_n,
   input wire logic halt_request_in,
   // bus side outputs
   output logic bus_busy_out,
   output logic bus_busy_oe_n,
   output logic wr_data_hold,
   output logic halt_indicator_out,
   output logic halt_indicator_oe_n,
   // core side events
   output logic beat_done,
   output logic rd_data_valid,
   output logic rd_data_discard,
   output logic xfer_done,
   output logic xfer_error,
   output logic ext_irq_take,
   output logic smi_take,
   output logic mchk_take,
   output logic checkstop
);

   localparam int CNT_W = $clog2(MAX_BEATS + 1);

   initial begin
      if (MAX_BEATS < 1) begin
         $error("bte_top needs at least one beat");
      end
   end

   // ----------------------------------------
   // synchronizers and reset strap
   // ----------------------------------------
   logic [3:0] async_sync;
   logic ext_irq_s;
   logic smi_s;
   logic mchk_n_s;
   logic halt_req_s;
   logic retry_off;

   // async pins go through the chain before any logic looks at them
   bte_sync #(.WIDTH(4), .STAGES(SYNC_STAGES)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in({halt_request_in, ~machine_check_in_n, sysmgmt_irq, ext_irq}),
      .sync_out(async_sync)
   );

   assign ext_irq_s = async_sync[0];
   assign smi_s = async_sync[1];
   assign mchk_n_s = ~async_sync[2];
   assign halt_req_s = async_sync[3];

   bte_strap u_strap (
      .core_clk(core_clk),
      .rst(rst),
      .strap_in(beat_retry),
      .strap_r(retry_off)
   );

   // ----------------------------------------
   // register state
   // ----------------------------------------
   logic [2:0] ctrl_r;
   logic [2:0] ctrl_nxt;
   logic [3:0] sticky_r;
   logic [3:0] sticky_nxt;
   logic [bte_pkg::DATA_W-1:0] reg_rdata_r;
   logic [bte_pkg::DATA_W-1:0] reg_rdata_nxt;

   // ----------------------------------------
   // tenure and exception state
   // ----------------------------------------
   bte_pkg::bte_state_e state_r;
   bte_pkg::bte_state_e state_nxt;
   logic rd_r;
   logic rd_nxt;
   logic [CNT_W-1:0] beats_r;
   logic [CNT_W-1:0] beats_nxt;
   logic [CNT_W-1:0] conf_r;
   logic [CNT_W-1:0] conf_nxt;
   logic pend_r;
   logic pend_nxt;
   logic busy_r;
   logic busy_nxt;
   logic mchk_n_d_r;
   logic mchk_n_d_nxt;
   logic ext_pend_r;
   logic ext_pend_nxt;
   logic smi_pend_r;
   logic smi_pend_nxt;
   logic beat_done_r;
   logic beat_done_nxt;
   logic rd_valid_r;
   logic rd_valid_nxt;
   logic rd_discard_r;
   logic rd_discard_nxt;
   logic xfer_done_r;
   logic xfer_done_nxt;
   logic xfer_error_r;
   logic xfer_error_nxt;
   logic ext_take_r;
   logic ext_take_nxt;
   logic smi_take_r;
   logic smi_take_nxt;
   logic mchk_take_r;
   logic mchk_take_nxt;
   logic hold_r;
   logic hold_nxt;
   logic mchk_event;
   logic bus_err_event;
   logic stop_now;

   // confirmed-beat count plus one, cut to counter width
   function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
      inc = CNT_W'(v + 1'b1);
   endfunction

   // falling edge of the synchronized pin, never from the first flop
   assign mchk_event = mchk_n_d_r & ~mchk_n_s;
   assign bus_err_event = (state_r == bte_pkg::BTE_BEAT) & bus_error_ack;

   // checkstop sources: halt pin, machine check pin with EMC on and ME off, or bus error with ME off
   always_comb begin
      stop_now = 1'b0;
      if (halt_req_s) begin
         stop_now = 1'b1;
      end else if (mchk_event & ctrl_r[bte_pkg::CTRL_EMC] & ~ctrl_r[bte_pkg::CTRL_ME]) begin
         stop_now = 1'b1;
      end else if (bus_err_event & ~ctrl_r[bte_pkg::CTRL_ME]) begin
         stop_now = 1'b1;
      end
   end

   // ----------------------------------------
   // data tenure sequencing
   // ----------------------------------------
   // with retry_off clear, read beats are confirmed one cycle late so a retry can cancel them
   always_comb begin
      state_nxt = state_r;
      rd_nxt = rd_r;
      beats_nxt = beats_r;
      conf_nxt = conf_r;
      pend_nxt = 1'b0;
      busy_nxt = busy_r;
      beat_done_nxt = 1'b0;
      rd_valid_nxt = 1'b0;
      rd_discard_nxt = 1'b0;
      xfer_done_nxt = 1'b0;
      xfer_error_nxt = 1'b0;
      hold_nxt = 1'b0;
      case (state_r)
         bte_pkg::BTE_IDLE: begin
            if (xfer_start) begin
               state_nxt = bte_pkg::BTE_BEAT;
               rd_nxt = xfer_read;
               beats_nxt = xfer_burst ? CNT_W'(MAX_BEATS) : CNT_W'(1);
               conf_nxt = '0;
               busy_nxt = 1'b1;
               hold_nxt = ~xfer_read;
            end
         end
         bte_pkg::BTE_BEAT: begin
            if (bus_error_ack) begin
               // error wins; acks and retries in this cycle are dropped
               state_nxt = bte_pkg::BTE_IDLE;
               busy_nxt = 1'b0;
               xfer_error_nxt = 1'b1;
            end else if (!rd_r) begin
               // writes: beat_retry is not looked at
               if (transfer_ack) begin
                  beat_done_nxt = 1'b1;
                  conf_nxt = inc(conf_r);
                  if (inc(conf_r) == beats_r) begin
                     state_nxt = bte_pkg::BTE_IDLE;
                     busy_nxt = 1'b0;
                     xfer_done_nxt = 1'b1;
                  end else begin
                     hold_nxt = 1'b1;
                  end
               end else begin
                  hold_nxt = 1'b1;
               end
            end else begin
               if (pend_r && !retry_off && beat_retry) begin
                  rd_discard_nxt = 1'b1;
               end else if (pend_r) begin
                  rd_valid_nxt = 1'b1;
                  conf_nxt = inc(conf_r);
               end
               if (transfer_ack) begin
                  beat_done_nxt = 1'b1;
                  if (retry_off) begin
                     rd_valid_nxt = 1'b1;
                     conf_nxt = inc(conf_r);
                  end else begin
                     pend_nxt = 1'b1;
                  end
               end
               // bus released at the last ack; tenure stays until confirmed
               if (transfer_ack && (conf_nxt + CNT_W'(pend_nxt) == beats_r)) begin
                  busy_nxt = 1'b0;
               end
               if (conf_nxt == beats_r) begin
                  state_nxt = bte_pkg::BTE_IDLE;
                  busy_nxt = 1'b0;
                  xfer_done_nxt = 1'b1;
               end
            end
         end
         default: begin
            busy_nxt = 1'b0;
         end
      endcase
      if (stop_now || state_r == bte_pkg::BTE_HALT) begin
         state_nxt = bte_pkg::BTE_HALT;
         busy_nxt = 1'b0;
         hold_nxt = 1'b0;
      end
   end

   // ----------------------------------------
   // exception taking
   // ----------------------------------------
   // one take per held level; a fresh take needs the level to drop first
   always_comb begin
      ext_take_nxt = 1'b0;
      smi_take_nxt = 1'b0;
      mchk_take_nxt = 1'b0;
      ext_pend_nxt = ext_pend_r & ext_irq_s;
      smi_pend_nxt = smi_pend_r & smi_s;
      mchk_n_d_nxt = mchk_n_s;
      if (state_r != bte_pkg::BTE_HALT && !stop_now) begin
         if (ext_irq_s && !ext_pend_r && ctrl_r[bte_pkg::CTRL_EE]) begin
            ext_take_nxt = 1'b1;
            ext_pend_nxt = 1'b1;
         end
         if (smi_s && !smi_pend_r && ctrl_r[bte_pkg::CTRL_EE]) begin
            smi_take_nxt = 1'b1;
            smi_pend_nxt = 1'b1;
         end
         if (mchk_event && ctrl_r[bte_pkg::CTRL_EMC] && ctrl_r[bte_pkg::CTRL_ME]) begin
            mchk_take_nxt = 1'b1;
         end
         if (bus_err_event && ctrl_r[bte_pkg::CTRL_ME]) begin
            mchk_take_nxt = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // register port
   // ----------------------------------------
   // sticky bits: a set in the clearing cycle survives the clear
   always_comb begin
      ctrl_nxt = ctrl_r;
      sticky_nxt = sticky_r;
      reg_rdata_nxt = '0;
      if (reg_wr) begin
         if (reg_addr == bte_pkg::REG_CTRL) begin
            ctrl_nxt = reg_wdata[2:0];
         end else if (reg_addr == bte_pkg::REG_STATUS) begin
            sticky_nxt = sticky_r & ~reg_wdata[bte_pkg::ST_BUS_ERR:bte_pkg::ST_EXT_TAKEN];
         end
      end
      sticky_nxt = sticky_nxt | {xfer_error_nxt, mchk_take_nxt, smi_take_nxt, ext_take_nxt};
      if (reg_rd) begin
         if (reg_addr == bte_pkg::REG_CTRL) begin
            reg_rdata_nxt[2:0] = ctrl_r;
         end else if (reg_addr == bte_pkg::REG_STATUS) begin
            reg_rdata_nxt[bte_pkg::ST_RETRY_OFF] = retry_off;
            reg_rdata_nxt[bte_pkg::ST_CHECKSTOP] = (state_r == bte_pkg::BTE_HALT);
            reg_rdata_nxt[bte_pkg::ST_BUS_ERR:bte_pkg::ST_EXT_TAKEN] = sticky_r;
            reg_rdata_nxt[bte_pkg::ST_BUSY] = (state_r == bte_pkg::BTE_BEAT);
         end
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= bte_pkg::BTE_IDLE;
         rd_r <= 1'b0;
         beats_r <= '0;
         conf_r <= '0;
         pend_r <= 1'b0;
         busy_r <= 1'b0;
         hold_r <= 1'b0;
         mchk_n_d_r <= 1'b1;
         ext_pend_r <= 1'b0;
         smi_pend_r <= 1'b0;
         beat_done_r <= 1'b0;
         rd_valid_r <= 1'b0;
         rd_discard_r <= 1'b0;
         xfer_done_r <= 1'b0;
         xfer_error_r <= 1'b0;
         ext_take_r <= 1'b0;
         smi_take_r <= 1'b0;
         mchk_take_r <= 1'b0;
         ctrl_r <= bte_pkg::CTRL_RESET;
         sticky_r <= bte_pkg::STICKY_RESET;
         reg_rdata_r <= '0;
      end else begin
         state_r <= state_nxt;
         rd_r <= rd_nxt;
         beats_r <= beats_nxt;
         conf_r <= conf_nxt;
         pend_r <= pend_nxt;
         busy_r <= busy_nxt;
         hold_r <= hold_nxt;
         mchk_n_d_r <= mchk_n_d_nxt;
         ext_pend_r <= ext_pend_nxt;
         smi_pend_r <= smi_pend_nxt;
         beat_done_r <= beat_done_nxt;
         rd_valid_r <= rd_valid_nxt;
         rd_discard_r <= rd_discard_nxt;
         xfer_done_r <= xfer_done_nxt;
         xfer_error_r <= xfer_error_nxt;
         ext_take_r <= ext_take_nxt;
         smi_take_r <= smi_take_nxt;
         mchk_take_r <= mchk_take_nxt;
         ctrl_r <= ctrl_nxt;
         sticky_r <= sticky_nxt;
         reg_rdata_r <= reg_rdata_nxt;
      end
   end

   // ----------------------------------------
   // outputs, all straight from flops except halt_indicator_out, which is tied low
   // ----------------------------------------
   // halt floats busy and asserts the open-drain indicator until reset
   assign bus_busy_out = busy_r;
   assign bus_busy_oe_n = ~busy_r;
   assign wr_data_hold = hold_r;
   assign halt_indicator_out = 1'b0; // open drain: only ever pulls low
   assign halt_indicator_oe_n = (state_r != bte_pkg::BTE_HALT);
   assign checkstop = state_r[2];
   assign reg_rdata = reg_rdata_r;
   assign beat_done = beat_done_r;
   assign rd_data_valid = rd_valid_r;
   assign rd_data_discard = rd_discard_r;
   assign xfer_done = xfer_done_r;
   assign xfer_error = xfer_error_r;
   assign ext_irq_take = ext_take_r;
   assign smi_take = smi_take_r;
   assign mchk_take = mchk_take_r;

endmodule
`default_nettype wire

// >>> bte_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// port checks for bte_top
// ------------------------------
module bte_top_assertions (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic transfer_ack,
   input wire logic beat_retry,
   input wire logic bus_error_ack,
   input wire logic ext_irq,
   input wire logic sysmgmt_irq,
   input wire logic machine_check_in_n,
   input wire logic halt_request_in,
   input wire logic bus_busy_out,
   input wire logic bus_busy_oe_n,
   input wire logic wr_data_hold,
   input wire logic halt_indicator_out,
   input wire logic halt_indicator_oe_n,
   input wire logic beat_done,
   input wire logic rd_data_discard,
   input wire logic xfer_error,
   input wire logic ext_irq_take,
   input wire logic smi_take,
   input wire logic mchk_take,
   input wire logic checkstop
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // bus error ends the tenure within one cycle
   a_err_float: assert property (bus_error_ack && !bus_busy_oe_n |=> bus_busy_oe_n && !bus_busy_out)
      else $error("busy still driven after bus error");
   a_err_report: assert property (bus_error_ack && !bus_busy_oe_n |=> xfer_error)
      else $error("bus error not reported");
   // write data held while the beat waits
   a_write_hold: assert property (wr_data_hold && !transfer_ack && !bus_error_ack |=> wr_data_hold)
      else $error("write data dropped before ack");
   a_beat_cause: assert property (beat_done |-> $past(transfer_ack) || $past(transfer_ack, 2))
      else $error("beat done without ack");
   a_discard_cause: assert property (rd_data_discard |-> $past(beat_retry))
      else $error("discard without retry");
   // takes need the level held through the sync chain
   a_ext_level: assert property (ext_irq_take |-> $past(ext_irq) && $past(ext_irq, 2))
      else $error("ext take without held level");
   a_smi_level: assert property (smi_take |-> $past(sysmgmt_irq) && $past(sysmgmt_irq, 2))
      else $error("smi take without held level");
   a_mchk_cause: assert property (mchk_take |-> !$past(machine_check_in_n, 2) || $past(bus_error_ack))
      else $error("machine check without cause");
   a_halt_stop: assert property ($rose(halt_request_in) |-> ##[1:4] checkstop)
      else $error("halt request not honoured");
   a_halt_float: assert property (checkstop |-> bus_busy_oe_n && !halt_indicator_oe_n && !halt_indicator_out)
      else $error("outputs not floated in checkstop");
   a_reset_quiet: assert property ($fell(rst) |-> halt_indicator_oe_n && bus_busy_oe_n)
      else $error("indicator not released by reset");
   c_discard: cover property (rd_data_discard);
   c_error: cover property (xfer_error);
   c_ext: cover property (ext_irq_take);
   c_stop: cover property (checkstop);
endmodule
`default_nettype wire

// >>> bte_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// external bus controller model
// ------------------------------
module bte_ctrl_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic bus_busy_out,
   input wire logic bus_busy_oe_n,
   input wire logic is_read,
   input wire logic [2:0] n_beats,
   input wire logic [1:0] wait_n,
   input wire logic [2:0] retry_beat,
   input wire logic [2:0] err_beat,
   input wire logic strap_retry,
   output logic transfer_ack,
   output logic beat_retry,
   output var logic bus_error_ack
);
   logic [2:0] beat_r;
   logic [1:0] wcnt_r;
   logic again_r;
   logic fin_r;
   logic rty_r;
   // strap level only matters at the first edge after reset release
   assign beat_retry = rty_r | strap_retry;
   // one beat at a time; acks only while the tenure is driven
   always_ff @(posedge core_clk) begin
      transfer_ack <= 1'b0;
      rty_r <= 1'b0;
      bus_error_ack <= 1'b0;
      if (rst || !bus_busy_out || bus_busy_oe_n) begin
         beat_r <= 3'h0;
         wcnt_r <= 2'h0;
         again_r <= 1'b0;
         fin_r <= 1'b0;
      end else if (!fin_r) begin
         if (again_r) begin
            transfer_ack <= is_read;
            rty_r <= 1'b1;
            again_r <= 1'b0;
            beat_r <= beat_r + 3'h1;
            fin_r <= (beat_r + 3'h1 == n_beats);
         end else if (wcnt_r != wait_n) begin
            wcnt_r <= wcnt_r + 2'h1;
         end else begin
            wcnt_r <= 2'h0;
            if (beat_r == err_beat) begin
               bus_error_ack <= 1'b1;
               fin_r <= 1'b1;
            end else begin
               transfer_ack <= 1'b1;
               if (beat_r == retry_beat) begin
                  again_r <= 1'b1;
               end else begin
                  beat_r <= beat_r + 3'h1;
                  fin_r <= (beat_r + 3'h1 == n_beats);
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> bte_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bte_top_bench;
   logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, xfer_start = 1'b0;
   logic xfer_read = 1'b0, xfer_burst = 1'b0, ext_irq = 1'b0, sysmgmt_irq = 1'b0;
   logic machine_check_in_n = 1'b1, halt_request_in = 1'b0, strap_retry = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [1:0] wait_n = 2'h0;
   logic [2:0] retry_beat = 3'h7, err_beat = 3'h7;
   logic transfer_ack, beat_retry, bus_error_ack, bus_busy_out, bus_busy_oe_n, checkstop;
   logic wr_data_hold, halt_indicator_out, halt_indicator_oe_n, beat_done, rd_data_valid;
   logic rd_data_discard, xfer_done, xfer_error, ext_irq_take, smi_take, mchk_take, rd_pend;
   logic [15:0] xq[$], tq[$], rq[$];
   logic [31:0] mq[$];
   logic [3:0] nv, nd;
   logic strap_seen = 1'b0;
   int fails = 0, n_tests = 0;
   always #12.5 core_clk = ~core_clk;
   bte_top bte_top_i (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .xfer_start, .xfer_read, .xfer_burst, .transfer_ack, .beat_retry, .bus_error_ack,
      .ext_irq, .sysmgmt_irq, .machine_check_in_n, .halt_request_in, .bus_busy_out,
      .bus_busy_oe_n, .wr_data_hold, .halt_indicator_out, .halt_indicator_oe_n, .beat_done,
      .rd_data_valid, .rd_data_discard, .xfer_done, .xfer_error, .ext_irq_take, .smi_take,
      .mchk_take, .checkstop);
   bte_ctrl_model bte_ctrl_model_i (.core_clk, .rst, .bus_busy_out, .bus_busy_oe_n,
      .is_read(xfer_read), .n_beats(xfer_burst ? 3'(bte_pkg::BURST_BEATS) : 3'h1), .wait_n,
      .retry_beat, .err_beat, .strap_retry, .transfer_ack, .beat_retry, .bus_error_ack);
   // ------------------------------
   // checking
   // ------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (fails == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // monitor pairs each result with the oldest note
   always @(posedge core_clk) begin
      rd_pend <= reg_rd;
      if (rd_pend) chk(reg_rdata & mq.pop_front(), 32'(rq.pop_front()));
      if (rst) {nv, nd} = 8'h0;
      nv = nv + 4'(rd_data_valid);
      nd = nd + 4'(rd_data_discard);
      if (xfer_done || xfer_error) begin
         chk({xfer_error, nd, nv}, xq.size() > 0 ? xq.pop_front() : 16'hffff);
         {nv, nd} = 8'h0;
      end
      if (ext_irq_take || smi_take || mchk_take)
         chk({ext_irq_take, smi_take, mchk_take}, tq.size() > 0 ? tq.pop_front() : 16'hffff);
   end
   // ------------------------------
   // drivers
   // ------------------------------
   task automatic do_reset(input logic strap);
      rst <= 1'b1;
      strap_retry <= strap;
      halt_request_in <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      strap_retry <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [15:0] e);
      mq.push_back(m);
      rq.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask
   // beats confirmed: all of a read without an error beat, none of a write
   task automatic xfer(input logic r, b, input logic [2:0] rb, eb, input logic [15:0] tk);
      int k;
      xfer_read <= r;
      xfer_burst <= b;
      retry_beat <= rb;
      err_beat <= eb;
      wait_n <= 2'($urandom % 4);
      if (eb != 3'h7) xq.push_back(16'h100);
      else xq.push_back({7'h0, 4'(r && rb != 3'h7 && !strap_seen), r ? (b ? 4'h4 : 4'h1) : 4'h0});
      if (tk != 16'h0) tq.push_back(tk);
      xfer_start <= 1'b1;
      @(posedge core_clk);
      xfer_start <= 1'b0;
      for (k = 0; k < 200 && xq.size() != 0; k++) @(posedge core_clk);
      repeat (4) @(posedge core_clk);
   endtask
   // pins held long past the sync chain and the two-cycle minimum
   task automatic exc(input logic [2:0] pins, input logic [15:0] tk);
      if (tk != 16'h0) tq.push_back(tk);
      ext_irq <= pins[2];
      sysmgmt_irq <= pins[1];
      machine_check_in_n <= !pins[0];
      repeat (6) @(posedge core_clk);
      {ext_irq, sysmgmt_irq, machine_check_in_n} <= 3'b001;
      repeat (4) @(posedge core_clk);
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   initial begin
      void'($urandom(43513));
      do_reset(1'b0);
      rd(bte_pkg::REG_STATUS, 32'h1, 16'h0);
      rd(8'h08, 32'hffffffff, 16'h0);
      wr(bte_pkg::REG_CTRL, 32'h7);
      rd(bte_pkg::REG_CTRL, 32'h7, 16'h7);
      xfer(1'b0, 1'b0, 3'h7, 3'h7, 16'h0);
      xfer(1'b0, 1'b1, 3'h1, 3'h7, 16'h0);
      xfer(1'b1, 1'b0, 3'h0, 3'h7, 16'h0);
      xfer(1'b1, 1'b1, 3'h2, 3'h7, 16'h0);
      xfer(1'b1, 1'b0, 3'h7, 3'h0, 16'h1);
      for (int i = 0; i < 4; i++) xfer(1'($urandom), 1'($urandom), 3'h7, 3'h7, 16'h0);
      rd(bte_pkg::REG_STATUS, 32'h20, 16'h20);
      exc(3'b100, 16'h4);
      exc(3'b010, 16'h2);
      exc(3'b001, 16'h1);
      wr(bte_pkg::REG_CTRL, 32'h6);
      exc(3'b110, 16'h0);
      wr(bte_pkg::REG_CTRL, 32'h3);
      exc(3'b001, 16'h0);
      // one take for a level held across two spans; the note goes in before the pin rises
      tq.push_back(16'h4);
      ext_irq <= 1'b1;
      repeat (6) @(posedge core_clk);
      exc(3'b100, 16'h0);
      wr(bte_pkg::REG_CTRL, 32'h4);
      exc(3'b001, 16'h0);
      chk({checkstop, halt_indicator_oe_n, bus_busy_oe_n}, 3'b101);
      do_reset(1'b1);
      strap_seen = 1'b1;
      chk(halt_indicator_oe_n, 1'b1);
      rd(bte_pkg::REG_STATUS, 32'h3, 16'h1);
      xfer(1'b1, 1'b0, 3'h7, 3'h7, 16'h0);
      wr(bte_pkg::REG_CTRL, 32'h0);
      xfer(1'b1, 1'b0, 3'h7, 3'h0, 16'h0);
      chk(checkstop, 1'b1);
      do_reset(1'b0);
      halt_request_in <= 1'b1;
      repeat (5) @(posedge core_clk);
      chk({checkstop, halt_indicator_oe_n, bus_busy_oe_n}, 3'b101);
      do_reset(1'b0);
      chk(32'(xq.size() + tq.size()), 32'h0);
      tally_and_finish();
   end
   // watchdog, well beyond the expected run
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      tally_and_finish();
   end
endmodule
bind bte_top bte_top_assertions bte_top_assertions_i (.core_clk, .rst, .transfer_ack,
   .beat_retry, .bus_error_ack, .ext_irq, .sysmgmt_irq, .machine_check_in_n, .halt_request_in,
   .bus_busy_out, .bus_busy_oe_n, .wr_data_hold, .halt_indicator_out, .halt_indicator_oe_n,
   .beat_done, .rd_data_discard, .xfer_error, .ext_irq_take, .smi_take, .mchk_take,
   .checkstop);
`default_nettype wire
